// ---- src/led_defs.svh ----
// offsets, field positions, reset values and timing counts of the led block
// assumes inclusion by the package and the design file only
`ifndef LED_DEFS_SVH
`define LED_DEFS_SVH
`define LED_SLOTS        5
`define LED_SIG_W        16
`define LED_SEL_W        4
`define LED_ADDR_W       8
`define LED_OFS_SEL      8'h00
`define LED_OFS_CTRL     8'h04
`define LED_OFS_STATUS   8'h08
`define LED_CTRL_INV_LSB 0
`define LED_CTRL_LATCH   8
`define LED_CTRL_ACK_LSB 12
`define LED_CTRL_ACT_LSB 16
`define LED_CTRL_INA_LSB 20
`define LED_ST_COND_LSB  8
`define LED_RST_INV      5'h00
`define LED_RST_LATCH    1'h0
`define LED_CLK_KHZ      100000
`define LED_BLINK_MS     250
`endif

// ---- src/led_indicator_logic.sv ----
// one front-panel led: five conditioned signals ored, colour pick, latch, blink
// assumes sig comes from logic on pclk; apb slave with zero wait states
// Functional notes
// - each of five slots may invert its selected signal; inversion off by default
// - or of conditioned slots true shows active colour, red by default
// - or false shows inactive colour, off by default
// - latch option holds the active indication after pick-up
// - acknowledge clears the hold only when no setting signal remains
// - acknowledge chosen from the same signal list, used only while latching
`timescale 1ns/1ps
`include "led_defs.svh"
module led_indicator_logic #(
  parameter int BLINK_HALF_CYCLES = `LED_BLINK_MS * `LED_CLK_KHZ
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   ce,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`LED_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic [`LED_SIG_W-1:0]  sig,
  output led_pkg::led_t               led
);
  import led_pkg::*;

  localparam logic [31:0] HALF_LAST = 32'(BLINK_HALF_CYCLES - 1);

  state_t                s;
  state_t                next_s;
  logic [`LED_SLOTS-1:0] cond;
  logic                  ored;
  logic                  ack;
  logic                  shown;

  // address decode: 0 sel, 1 ctrl, 2 status, 3 unmapped
  function automatic logic [1:0] reg_index(input logic [`LED_ADDR_W-1:0] a);
    case (a)
      `LED_OFS_SEL:    reg_index = 2'h0;
      `LED_OFS_CTRL:   reg_index = 2'h1;
      `LED_OFS_STATUS: reg_index = 2'h2;
      default:         reg_index = 2'h3;
    endcase
  endfunction

  // colour to led drive
  function automatic led_t drive(input colour_t c, input logic b);
    led_t d;
    d = '0;
    case (c)
      C_GREEN:  d.green = 1'b1;
      C_RED:    d.red   = 1'b1;
      C_RED_FL: d.red   = b;
      C_GRN_FL: d.green = b;
      default:  d = '0;
    endcase
    return d;
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < `LED_SLOTS; gi++) begin : g_slot
      assign cond[gi] = sig[s.cfg.sel[gi]] ^ s.cfg.inv[gi];
    end
  endgenerate

  assign ored  = |cond;
  assign ack   = sig[s.cfg.ack_sel] & s.cfg.latch;
  assign shown = ored | s.held;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & (reg_index(paddr) == 2'h3);
  assign prdata  = s.prdata;
  assign led     = s.led;

  always_comb begin
    next_s = s;
    // pick-up holds; ack only when setting signals gone
    if (!s.cfg.latch) begin
      next_s.held = 1'b0;
    end else if (ored) begin
      next_s.held = 1'b1;
    end else if (ack) begin
      next_s.held = 1'b0;
    end
    if (s.cnt >= HALF_LAST) begin
      next_s.cnt   = '0;
      next_s.blink = ~s.blink;
    end else begin
      next_s.cnt = s.cnt + 32'h1;
    end
    next_s.led = drive(shown ? s.cfg.act_col : s.cfg.inact_col, s.blink);
    // register read data in setup phase
    if (psel && !penable && !pwrite) begin
      case (reg_index(paddr))
        2'h0:    next_s.prdata = 32'(s.cfg.sel);
        2'h1:    next_s.prdata = (32'(s.cfg.inv) << `LED_CTRL_INV_LSB)
                               | (32'(s.cfg.latch) << `LED_CTRL_LATCH)
                               | (32'(s.cfg.ack_sel) << `LED_CTRL_ACK_LSB)
                               | (32'(s.cfg.act_col) << `LED_CTRL_ACT_LSB)
                               | (32'(s.cfg.inact_col) << `LED_CTRL_INA_LSB);
        2'h2:    next_s.prdata = {19'h0, cond, 3'h0, s.blink, s.led, s.held, ored};
        default: next_s.prdata = 32'h0;
      endcase
    end
    if (psel && penable && pwrite) begin
      case (reg_index(paddr))
        2'h0: begin
          next_s.cfg.sel = pwdata[`LED_SLOTS*`LED_SEL_W-1:0];
        end
        2'h1: begin
          next_s.cfg.inv       = pwdata[`LED_CTRL_INV_LSB +: `LED_SLOTS];
          next_s.cfg.latch     = pwdata[`LED_CTRL_LATCH];
          next_s.cfg.ack_sel   = pwdata[`LED_CTRL_ACK_LSB +: `LED_SEL_W];
          next_s.cfg.act_col   = colour_t'(pwdata[`LED_CTRL_ACT_LSB +: 3]);
          next_s.cfg.inact_col = colour_t'(pwdata[`LED_CTRL_INA_LSB +: 3]);
        end
        default: next_s.cfg = s.cfg;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s               <= '0;
      s.cfg.inv       <= `LED_RST_INV;
      s.cfg.latch     <= `LED_RST_LATCH;
      s.cfg.act_col   <= C_RED;
      s.cfg.inact_col <= C_OFF;
    end else if (ce) begin
      s <= next_s;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_invert_all: assert property (
    ce && !s.cfg.latch && (&s.cfg.inv) && sig == 16'h0 && s.cfg.act_col == C_GREEN
    |=> s.led.green && !s.led.red) else $error("inverted slots did not light");

  chk_active_red: assert property (
    ce && shown && s.cfg.act_col == C_RED |=> s.led.red && !s.led.green)
    else $error("active red not shown");

  chk_active_off: assert property (
    ce && shown && s.cfg.act_col == C_OFF |=> s.led == 2'h0)
    else $error("active off not dark");

  chk_inactive_off: assert property (
    ce && !shown && s.cfg.inact_col == C_OFF |=> s.led == 2'h0)
    else $error("inactive off not dark");

  chk_inactive_green: assert property (
    ce && !shown && s.cfg.inact_col == C_GREEN |=> s.led.green && !s.led.red)
    else $error("inactive green not shown");

  chk_hold_pickup: assert property (
    ce && s.cfg.latch && ored ##1 ce && s.cfg.latch && !ack |=> s.held)
    else $error("latched indication lost");

  chk_hold_set: assert property (
    ce && s.cfg.latch && ored |=> s.held)
    else $error("pick-up did not set hold");

  chk_ack_blocked: assert property (
    ce && s.held && s.cfg.latch && ored |=> s.held)
    else $error("ack cleared while signal present");

  chk_ack_clears: assert property (
    ce && s.held && s.cfg.latch && !ored && sig[s.cfg.ack_sel] |=> !s.held)
    else $error("ack did not clear hold");

  chk_no_latch: assert property (
    ce && !s.cfg.latch |=> !s.held)
    else $error("hold without latch");

  chk_blink_toggle: assert property (
    ce && s.cnt >= HALF_LAST |=> s.blink != $past(s.blink))
    else $error("blink phase did not toggle");

  chk_blink_steady: assert property (
    ce && s.cnt < HALF_LAST |=> s.blink == $past(s.blink))
    else $error("blink phase moved early");

  chk_flash_red: assert property (
    ce && shown && s.cfg.act_col == C_RED_FL |=> s.led.red == $past(s.blink) && !s.led.green)
    else $error("red flash out of phase");

  chk_flash_green: assert property (
    ce && !shown && s.cfg.inact_col == C_GRN_FL |=> s.led.green == $past(s.blink)
    && !s.led.red) else $error("green flash out of phase");

  chk_ce_freeze: assert property (
    !ce |=> s == $past(s))
    else $error("state changed while enable low");

  cov_hold_set:    cover property (ce && s.cfg.latch && ored ##1 !ored && s.held);
  cov_ack_clear:   cover property (s.held ##1 !s.held && s.cfg.latch);
  cov_flash:       cover property (s.cfg.act_col == C_RED_FL && shown ##1 s.led.red);
  cov_green_flash: cover property (s.cfg.inact_col == C_GRN_FL && !shown ##1 s.led.green);
  cov_inverted:    cover property (ce && (&s.cfg.inv) && ored);
endmodule

// ---- src/led_pkg.sv ----
// types of the led indicator block
// assumes led_defs.svh on the include path
`include "led_defs.svh"
package led_pkg;
  typedef enum logic [2:0] {
    C_OFF     = 3'h0,
    C_GREEN   = 3'h1,
    C_RED     = 3'h2,
    C_RED_FL  = 3'h3,
    C_GRN_FL  = 3'h4
  } colour_t;

  typedef struct packed {
    logic red;
    logic green;
  } led_t;

  typedef struct packed {
    logic [`LED_SLOTS-1:0][`LED_SEL_W-1:0] sel;
    logic [`LED_SLOTS-1:0]                 inv;
    logic                                  latch;
    logic [`LED_SEL_W-1:0]                 ack_sel;
    colour_t                               act_col;
    colour_t                               inact_col;
  } cfg_t;

  typedef struct packed {
    cfg_t        cfg;
    logic        held;
    logic        blink;
    logic [31:0] cnt;
    logic [31:0] prdata;
    led_t        led;
  } state_t;
endpackage

// ---- verif/led_indicator_logic_tb.sv ----
// testbench of led_indicator_logic: apb master, cycle model of the led, panel model
// assumes src/ compiled first; blink half period shortened to 4 cycles
`timescale 1ns/1ps
module led_indicator_logic_tb;
  import led_pkg::*;
  localparam int H = 4;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err, m_or;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, m_ctrl, wsel, wctrl, exp_st;
  logic [15:0] sig;
  logic [19:0] m_sel;
  logic [1:0]  m_led;
  logic        m_held, m_blink;
  led_t        led;
  int          red_on, m_red, m_cnt, num_errors, total_checks, i, j, k;
  led_indicator_logic #(.BLINK_HALF_CYCLES(H)) dut (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sig(sig), .led(led));
  led_panel_model panel (.pclk(pclk), .led(led), .red_on(red_on));
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  function automatic logic [1:0] colour(logic [2:0] c, logic b);
    case (c)
      3'h1: return 2'b01;
      3'h2: return 2'b10;
      3'h3: return b ? 2'b10 : 2'b00;
      3'h4: return b ? 2'b01 : 2'b00;
      default: return 2'b00;
    endcase
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      tally_and_finish();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
    end
  endtask
  // cycle model of the led
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_sel <= 0; m_ctrl <= 32'h0002_0000; m_held <= 0; m_blink <= 0; m_cnt <= 0; m_led <= 0;
    end else if (ce) begin
      m_or = 0;
      for (j = 0; j < 5; j++) m_or = m_or | (sig[m_sel[4*j+:4]] ^ m_ctrl[j]);
      m_led <= colour((m_or | m_held) ? m_ctrl[18:16] : m_ctrl[22:20], m_blink);
      m_held <= m_ctrl[8] && (m_or || (m_held && !sig[m_ctrl[15:12]]));
      m_cnt <= (m_cnt == H - 1) ? 0 : m_cnt + 1;
      if (m_cnt == H - 1) m_blink <= !m_blink;
      if (psel && penable && pwrite && paddr == 8'h00) m_sel <= pwdata[19:0];
      if (psel && penable && pwrite && paddr == 8'h04) m_ctrl <= pwdata;
    end
  end
  initial m_red = 0;
  always @(posedge pclk) if (m_led[1]) m_red++;
  always @(negedge pclk) begin
    if (presetn) check("led", {30'h0, led}, {30'h0, m_led});
  end
  initial begin
    presetn = 0; ce = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; sig = 0;
    num_errors = 0; total_checks = 0;
    void'($urandom(36));
    repeat (12) @(posedge pclk);
    presetn <= 1;
    apb(1'b0, 8'h04, 32'h0);
    check("ctrl reset", rd, 32'h0002_0000);
    apb(1'b0, 8'h0c, 32'h0);
    check("unmapped err", {31'h0, err}, 32'h1);
    $display("test defaults done");
    apb(1'b1, 8'h04, 32'h0001_001f);
    repeat (8) @(posedge pclk);
    @(negedge pclk);
    check("inverted green", {30'h0, led}, 32'h1);
    $display("test inversion done");
    for (i = 0; i < 25; i++) begin
      wsel = $urandom & 32'h000f_ffff;
      apb(1'b1, 8'h00, wsel);
      // every colour pair, random slots, inversion, latch, ack
      wctrl = {9'h0, 3'(i / 5), 1'b0, 3'(i % 5), 4'($urandom), 3'h0, 1'($urandom),
               3'h0, 5'($urandom)};
      apb(1'b1, 8'h04, wctrl);
      repeat (40) begin
        @(posedge pclk);
        sig <= 16'($urandom);
        ce <= ($urandom % 8) != 0;
      end
      @(posedge pclk);
      ce <= 1;
      apb(1'b0, 8'h00, 32'h0);
      check("sel readback", rd, wsel);
      apb(1'b0, 8'h04, 32'h0);
      check("ctrl readback", rd, wctrl);
      apb(1'b0, 8'h08, 32'h0);
      exp_st = {30'h0, m_held, m_or};
      for (k = 0; k < 5; k++) exp_st[8+k] = sig[m_sel[4*k+:4]] ^ m_ctrl[k];
      check("status", rd & 32'h0000_1f03, exp_st);
    end
    $display("test random done");
    @(posedge pclk);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    apb(1'b0, 8'h04, 32'h0);
    check("ctrl after reset", rd, 32'h0002_0000);
    apb(1'b0, 8'h00, 32'h0);
    check("sel after reset", rd, 32'h0);
    $display("test midrun reset done");
    check("panel red", 32'(red_on), 32'(m_red));
    tally_and_finish();
  end
endmodule

// ---- verif/led_panel_model.sv ----
// front-panel two-colour led: counts the cycles its red die is lit
// assumes led changes only just after rising edges of pclk
`timescale 1ns/1ps
module led_panel_model (
  input  wire logic          pclk,
  input  wire led_pkg::led_t led,
  output int                 red_on
);
  initial red_on = 0;
  always @(posedge pclk) begin
    if (led.red === 1'b1) red_on <= red_on + 1;
  end
endmodule
